/* File: hw/squitter_payload_assembler.sv */
// extended squitter frame assembler with per register scheduling
`timescale 1ns/1ps
`default_nettype none
module squitter_payload_assembler
    import squitter_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // identity and mode
    input wire logic [23:0] aircraft_address,
    input wire logic on_surface,
    // common data source, shared with the reply path
    input wire logic [9:0] store_valid,
    input wire logic [9*51-1:0] store_data_flat,
    input wire logic [9:0][4:0] store_type_code,
    input wire logic [9:0][31:0] rate_period,
    // frame out to transmitter
    output logic [111:0] frame_data,
    output logic frame_valid,
    output logic [3:0] frame_sel,
    input wire logic frame_ready,
    // flags
    output logic [9:0] type_code_error
);

    // ****************************************
    // flat input view: 10 slots of 51 bits
    // ****************************************
    logic [50:0] store_data [msg_count];
    logic [msg_count-1:0] due_q;
    logic [msg_count-1:0] due_set;
    logic [msg_count-1:0] bad_code;
    logic [31:0] tick_q [msg_count];
    logic [111:0] frame_d;
    logic [3:0] pick;
    logic pick_ok;

    genvar gi;
    generate
        for (gi = 0; gi < msg_count; gi++)
        begin : g_slot
            if (gi < 9)
            begin : g_flat
                assign store_data[gi] = store_data_flat[gi*51 +: 51];
            end
            else
            begin : g_share
                // 0a slot carries store 07 data path, both only complete the protocol
                assign store_data[gi] = store_data_flat[8*51 +: 51];
            end
            // independent period counter per slot
            // compare with >= so a period lowered at run time still wraps
            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                begin
                    tick_q[gi] <= 32'h0;
                end
                else if (tick_q[gi] >= rate_period[gi > 8 ? 8 : gi])
                begin
                    tick_q[gi] <= 32'h0;
                end
                else
                begin
                    tick_q[gi] <= tick_q[gi] + 32'h1;
                end
            end
            assign due_set[gi] = (tick_q[gi] >= rate_period[gi > 8 ? 8 : gi]);
        end
    endgenerate

    // ****************************************
    // input conditioning for level flags
    // ****************************************
    // valid flags and ground mode come from avionics on their own clocks
    // data words are not synchronised; they are qualified by the valid flags
    logic [10:0] raw_in;
    logic [10:0] sync1_q;
    logic [10:0] sync2_q;
    logic [10:0] sync3_q;
    logic [10:0] level_q;
    logic [9:0] store_valid_s;
    logic on_surface_s;

    assign raw_in = {on_surface, store_valid};

    generate
        for (gi = 0; gi < 11; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // agreement filter
    // ****************************************
    // a change counts only once stages two and three agree
    generate
        for (gi = 0; gi < 11; gi++)
        begin : g_agree
            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                    level_q[gi] <= 1'b0;
                else if (sync2_q[gi] == sync3_q[gi])
                    level_q[gi] <= sync3_q[gi];
            end
        end
    endgenerate

    assign store_valid_s = level_q[9:0];
    assign on_surface_s = level_q[10];

    // ****************************************
    // per slot type code table and legality
    // ****************************************
    logic [msg_count-1:0][7:0] slot_code;

    generate
        for (gi = 0; gi < msg_count; gi++)
        begin : g_code
            if (gi == 0)
            begin : g_air
                // the chosen code also carries the containment bound
                assign slot_code[gi] = {store_type_code[gi], 3'h0};
                assign bad_code[gi] = !((store_type_code[gi] == 5'h00)
                    || ((store_type_code[gi] >= 5'h09) && (store_type_code[gi] <= 5'h12))
                    || ((store_type_code[gi] >= 5'h14) && (store_type_code[gi] <= 5'h16)));
            end

            else if (gi == 1)
            begin : g_surf
                assign slot_code[gi] = {store_type_code[gi], 3'h0};
                assign bad_code[gi] = !((store_type_code[gi] == 5'h00)
                    || ((store_type_code[gi] >= 5'h05) && (store_type_code[gi] <= 5'h08)));
            end

            else if (gi == 2)
            begin : g_ident
                assign slot_code[gi] = {store_type_code[gi], 3'h0};
                assign bad_code[gi] = !((store_type_code[gi] >= 5'h01)
                    && (store_type_code[gi] <= 5'h04));
            end

            else if (gi == 3)
            begin : g_velocity
                // subtype travels in the data word, source picks 1 or 2
                assign slot_code[gi] = {tc_velocity, 3'h0};
                assign bad_code[gi] = 1'b0;
            end

            else if (gi == 4)
            begin : g_emergency
                assign slot_code[gi] = {tc_status, st_emergency};
                assign bad_code[gi] = 1'b0;
            end

            else if (gi == 5)
            begin : g_advisory
                assign slot_code[gi] = {tc_status, st_advisory};
                assign bad_code[gi] = 1'b0;
            end

            else if (gi == 6)
            begin : g_target
                // fixed pair, nothing for the source to get wrong
                assign slot_code[gi] = {tc_target_state, st_target};
                assign bad_code[gi] = 1'b0;
            end

            else if (gi == 7)
            begin : g_op_status
                // ground mode comes through the filter, so no glitch flips the subtype
                assign slot_code[gi] = {tc_op_status, on_surface_s ? st_surface : st_airborne};
                assign bad_code[gi] = 1'b0;
            end

            else if (gi == 8)
            begin : g_store_07
                // carries no broadcast items, kept to complete the protocol
                assign slot_code[gi] = {tc_reserved_07, 3'h0};
                assign bad_code[gi] = 1'b0;
            end

            else
            begin : g_store_0a
                // carries no broadcast items, kept to complete the protocol
                assign slot_code[gi] = {tc_reserved_0a, 3'h0};
                assign bad_code[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************
    // due flags: set wins over clear
    // ****************************************
    always_comb
    begin
        pick = 4'h0;
        pick_ok = 1'b0;
        for (int i = msg_count - 1; i >= 0; i--)
        begin
            if (due_q[i] && store_valid_s[i > 8 ? 8 : i] && !bad_code[i])
            begin
                pick = 4'(i);
                pick_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            due_q <= '0;
        end
        else
        begin
            for (int i = 0; i < msg_count; i++)
            begin
                // set wins so a tick in the send cycle is never lost
                if (due_set[i])
                begin
                    due_q[i] <= 1'b1;
                end
                else if ((!frame_valid || frame_ready) && pick_ok && pick == 4'(i))
                begin
                    due_q[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // frame build
    // ****************************************
    always_comb
    begin
        logic [55:0] me;
        me = 56'h0;
        if (pick <= 4'h3)
            me = {slot_code[pick][7:3], store_data[pick]};
        else
            me = {slot_code[pick], store_data[pick][47:0]};
        // data comes unmodified from the shared store used by replies
        frame_d = {format_code, capability_code, aircraft_address,
                   me, 24'h0};
    end

    // ****************************************
    // frame output register
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            frame_valid <= 1'b0;
            frame_data <= 112'h0;
            frame_sel <= 4'h0;
        end
        else if (!frame_valid || frame_ready)
        begin
            frame_valid <= pick_ok;
            if (pick_ok)
            begin
                frame_data <= frame_d;
                frame_sel <= pick;
            end
        end
    end

    // ****************************************
    // illegal type code flags
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            type_code_error <= 10'h0;
        end
        else
        begin
            type_code_error <= bad_code;
        end
    end

endmodule : squitter_payload_assembler
`default_nettype wire

/* File: hw/squitter_pkg.sv */
// constants and types for the extended squitter payload assembler
// Functional notes
// - selected register content fills the 56-bit payload, frame bits 33 to 88.
// - first five payload bits carry the type code naming the message category.
// - airborne position type 0,9-18,20-22; surface 0,5-8; code encodes containment bound.
// - identification and category from register 08 hex use type code 1 to 4.
// - velocity 19 sub 1/2; status 28 sub 1/2; operational status 31 sub 0/1.
// - target state and status from register 62 hex uses type 29 subtype 1.
// - every frame carries the 24-bit aircraft address in frame bits 9 to 32.
// - data shared with interrogation replies comes from one common source.
// - registers 07 hex and 0a hex are implemented though they carry no broadcast data.
// - each register is loaded and sent at its own rate, independently of others; register 0a hex uses the data, period and valid flag of register 07 hex.
package squitter_pkg;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int frame_bits = 112;
    localparam int payload_bits = 56;
    localparam int address_bits = 24;
    localparam int type_code_bits = 5;
    localparam int subtype_bits = 3;
    localparam int msg_count = 10;
    localparam logic [4:0] format_code = 5'h11;
    localparam logic [2:0] capability_code = 3'h5;

    // ****************************************
    // type and subtype codes
    // ****************************************
    localparam logic [4:0] tc_velocity = 5'h13;
    localparam logic [4:0] tc_status = 5'h1c;
    localparam logic [4:0] tc_target_state = 5'h1d;
    localparam logic [4:0] tc_op_status = 5'h1f;
    localparam logic [4:0] tc_reserved_07 = 5'h17;
    localparam logic [4:0] tc_reserved_0a = 5'h18;
    localparam logic [2:0] st_emergency = 3'h1;
    localparam logic [2:0] st_advisory = 3'h2;
    localparam logic [2:0] st_target = 3'h1;
    localparam logic [2:0] st_airborne = 3'h0;
    localparam logic [2:0] st_surface = 3'h1;

    // ****************************************
    // message slots, one per data store register
    // ****************************************
    typedef enum logic [3:0] {
        msg_air_pos = 4'h0,
        msg_surf_pos = 4'h1,
        msg_ident = 4'h2,
        msg_velocity = 4'h3,
        msg_emergency = 4'h4,
        msg_advisory = 4'h5,
        msg_target = 4'h6,
        msg_op_status = 4'h7,
        msg_store_07 = 4'h8,
        msg_store_0a = 4'h9
    } msg_sel_t;

    // ****************************************
    // default periods in ref_clk cycles (overridable)
    // ****************************************
    localparam int period_w = 32;
    localparam logic [31:0] period_default = 32'h02faf080;

endpackage : squitter_pkg

/* File: sim/squitter_assertions.sv */
// port checks for the squitter assembler
`timescale 1ns/1ps
`default_nettype none
module squitter_assertions
    import squitter_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [23:0] aircraft_address,
    input wire logic on_surface,
    input wire logic frame_ready,
    input wire logic [111:0] frame_data,
    input wire logic frame_valid,
    input wire logic [3:0] frame_sel
);
    // slot 4'hf never exists, so it stands for no frame
    wire logic [3:0] sel = frame_valid ? frame_sel : 4'hf;
    wire logic [7:0] ts = frame_data[79:72];
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    AST_ADDR: assert property (frame_valid |-> frame_data[103:80] == aircraft_address)
        else $error("address wrong");
    AST_AIR: assert property (sel == 4'h0 |-> ts[7:3] inside {5'h00, [5'h09:5'h12], [5'h14:5'h16]})
        else $error("airborne code");
    AST_SURF: assert property (sel == 4'h1 |-> ts[7:3] inside {5'h00, [5'h05:5'h08]})
        else $error("surface code");
    AST_IDENT: assert property (sel == 4'h2 |-> ts[7:3] inside {[5'h01:5'h04]})
        else $error("ident code");
    AST_STAT: assert property (sel inside {4'h4, 4'h5} |-> ts == {tc_status, sel[0] ? st_advisory : st_emergency})
        else $error("status code");
    AST_TGT: assert property (sel == 4'h6 |-> ts == {tc_target_state, st_target})
        else $error("target code");
    AST_OPST: assert property (sel == 4'h7 |-> ts == {tc_op_status, on_surface ? st_surface : st_airborne})
        else $error("op status code");
    AST_HOLD: assert property (frame_valid && !frame_ready |=> frame_valid && $stable({frame_sel, frame_data}))
        else $error("frame dropped");
    cover property (sel == 4'h9 && frame_ready);
    cover property (sel == 4'h7 && on_surface);
    cover property (frame_valid && !frame_ready ##1 frame_ready);
endmodule : squitter_assertions
bind squitter_payload_assembler squitter_assertions squitter_assertions_inst (.ref_clk, .resetn,
    .aircraft_address, .on_surface, .frame_ready, .frame_data, .frame_valid, .frame_sel);
`default_nettype wire

/* File: sim/frame_sink.sv */
// transmitter model: takes a frame after a set stall
`timescale 1ns/1ps
`default_nettype none
module frame_sink
(
    input wire logic ref_clk,
    input wire logic [111:0] frame_data,
    input wire logic frame_valid,
    input wire logic [3:0] frame_sel,
    input wire logic [3:0] stall,
    output logic frame_ready,
    output logic [111:0] got_data,
    output logic [3:0] got_sel,
    output int got_n
);
    int w = 0;
    initial frame_ready = 1'b0;
    initial got_n = 0;
    always @(posedge ref_clk)
        if (frame_valid && frame_ready)
        begin
            got_data <= frame_data;
            got_sel <= frame_sel;
            got_n <= got_n + 1;
        end
    // one-cycle accept, so back-to-back frames see a bubble
    always @(negedge ref_clk)
    begin
        frame_ready <= frame_valid && !frame_ready && w >= int'(stall);
        w <= (frame_valid && !frame_ready) ? w + 1 : 0;
    end
endmodule : frame_sink
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the squitter assembler
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import squitter_pkg::*;
;
    logic ref_clk = 1'b0, resetn = 1'b0, on_surface = 1'b0, frame_valid, frame_ready;
    logic [23:0] aircraft_address = 24'h3c5a96;
    logic [9:0] store_valid = 10'h1ff;
    logic [9:0] type_code_error;
    logic [458:0] store_data_flat;
    logic [9:0][4:0] store_type_code = {35'h0, 5'h03, 5'h06, 5'h0b};
    logic [9:0][31:0] rate_period = {10{32'h14}};
    logic [111:0] frame_data, got_data;
    logic [3:0] frame_sel, got_sel, stall = 4'h0;
    int got_n, cyc = 0, mismatches = 0, cmp_count = 0;
    squitter_payload_assembler squitter_payload_assembler_inst (.ref_clk, .resetn,
        .aircraft_address, .on_surface, .store_valid, .store_data_flat, .store_type_code,
        .rate_period, .frame_data, .frame_valid, .frame_sel, .frame_ready, .type_code_error);
    frame_sink frame_sink_inst (.ref_clk, .frame_data, .frame_valid, .frame_sel, .stall,
        .frame_ready, .got_data, .got_sel, .got_n);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (cyc++ == 4000)
        begin
            mismatches++;
            finish_test();
        end
    task automatic check(input logic [55:0] seen, input logic [55:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask : check
    task automatic finish_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    function automatic logic [7:0] exp_code(input int s);
        case (s)
            3: return {tc_velocity, store_data_flat[3 * 51 + 48 +: 3]};
            4: return {tc_status, st_emergency};
            5: return {tc_status, st_advisory};
            6: return {tc_target_state, st_target};
            7: return {tc_op_status, on_surface ? st_surface : st_airborne};
            8: return {tc_reserved_07, 3'h0};
            default: return {tc_reserved_0a, 3'h0};
        endcase
    endfunction : exp_code
    task automatic run_slot(input int s);
        int n = 0;
        int c0 = got_n;
        int k = s > 8 ? 8 : s;
        store_valid = 10'h001 << k;
        stall = 4'(s);
        while (n < 300 && (got_n == c0 || got_sel !== 4'(s)))
        begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 300, 1'b1);
        check(got_data[103:80], aircraft_address);
        check(got_data[71:24], store_data_flat[k * 51 +: 48]);
        if (s < 3)
            check(got_data[79:72], {store_type_code[s], store_data_flat[k * 51 + 48 +: 3]});
        else
            check(got_data[79:72], exp_code(s));
    endtask : run_slot
    task automatic refuse_test;
        store_type_code[0] = 5'h13;
        store_valid = 10'h001;
        repeat (60) @(negedge ref_clk);
        check(type_code_error[0], 1'b1);
        check(got_sel == 4'h0, 1'b0);
        store_type_code[0] = 5'h0b;
        run_slot(0);
    endtask : refuse_test
    task automatic ground_test;
        on_surface = 1'b1;
        store_type_code[1] = 5'h00;
        run_slot(1);
        run_slot(7);
    endtask : ground_test
    initial
    begin
        for (int i = 0; i < 9; i++)
            store_data_flat[i * 51 +: 51] = {3'h1, 48'h5a00_0000_0000 | 48'(i)};
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        wait (got_n == 2);
        check(got_sel, 4'h1);
        @(negedge ref_clk);
        for (int s = 0; s < 10; s++)
            run_slot(s);
        refuse_test();
        ground_test();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
